// [core/rpm_pkg.sv]
// Purpose: Shared constants and types for the port 0 RMII pin mode control
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes:   Offsets are byte addresses
package rpm_pkg;

   // =====================================================================
   // Register offsets
   localparam logic [7:0] RPM_OFS_BASIC_CTRL   = 8'h00;
   localparam logic [7:0] RPM_OFS_SPECIAL_CTRL = 8'h04;
   localparam logic [7:0] RPM_OFS_STATUS       = 8'h08;

   // =====================================================================
   // Basic control field positions and reset values
   localparam int RPM_BC_DUPLEX = 8;
   localparam int RPM_BC_ISO    = 10;
   localparam int RPM_BC_AN     = 12;
   localparam int RPM_BC_SPEED  = 13;
   localparam logic RPM_RST_ISO    = 1'b0;
   localparam logic RPM_RST_AN     = 1'b1;
   localparam logic RPM_RST_SPEED  = 1'b1;
   localparam logic RPM_RST_DUPLEX = 1'b1;

   // =====================================================================
   // Special control field positions and reset values
   localparam int RPM_SC_CLK_DIR = 0;
   localparam int RPM_SC_CLK_STR = 1;
   localparam logic RPM_RST_CLK_DIR = 1'b0;
   localparam logic RPM_RST_CLK_STR = 1'b0;

   // =====================================================================
   // Status field positions
   localparam int RPM_ST_MODE    = 0;
   localparam int RPM_ST_SPEED   = 1;
   localparam int RPM_ST_DUPLEX  = 2;
   localparam int RPM_ST_STRAP   = 4;
   localparam int RPM_ST_SPD_POL = 8;
   localparam int RPM_ST_DUP_POL = 9;
   localparam int RPM_ST_LATCHED = 10;
   localparam int RPM_ST_EDGES   = 16;

   // =====================================================================
   // Strap decode and timing
   localparam int         RPM_STRAP_W        = 3;
   localparam logic [2:0] RPM_STRAP_PHY_CODE = 3'h1;
   localparam logic [1:0] RPM_CAP_DELAY      = 2'h2;
   localparam int         RPM_REFCLK_MHZ     = 50;
   localparam int         RPM_MCLK_MHZ       = 10;
   localparam logic [7:0] RPM_DIV_HALF       = 8'h01;

   typedef enum logic {RPM_MODE_MAC, RPM_MODE_PHY} rpm_mode_t;

endpackage

// [core/rpm_sync.sv]
// Purpose: Two-stage synchroniser for a group of pin inputs
// Assumes: Inputs are asynchronous to i_mclk
// Notes:   Only the second stage is visible outside
`timescale 1ns/1ps
module rpm_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             i_mclk,
   input  wire logic             i_reset,
   // Data
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } rpm_sync_state_t;

   rpm_sync_state_t st;
   rpm_sync_state_t next_st;

   always_comb
   begin
      next_st.meta   = i_async;
      next_st.stable = st.meta;
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_reset)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign o_sync = st.stable;

endmodule // rpm_sync

// [core/rpm_pin_mode.sv]
// Purpose: Port 0 RMII pin modes: valid pin, speed, duplex, reference clock
// Assumes: Straps and pins are asynchronous; tx_en/crs_dv come from i_mclk
// Notes:   All outputs registered; APB answers with one wait state
// Function
// - MAC mode: output valid pin carries TX_EN toward external PHY.
// - PHY mode: output valid pin carries CRS_DV toward external MAC.
// - PHY mode with isolate set: output valid driver is off.
// - MAC mode: speed pin is a live value, followed continuously.
// - Autoneg cleared: speed comes from control register speed bit.
// - Speed pin polarity set by the speed polarity strap.
// - MAC mode: duplex pin is a live value, followed continuously.
// - Autoneg cleared: duplex comes from control register duplex bit.
// - Duplex pin polarity set by the duplex polarity strap.
// - PHY mode: speed and duplex pins are ignored.
// - Reference clock times all port data and valid pins; here the valid pin is registered on i_mclk.
// - Clock direction bit low makes refclk input, high makes output.
// - Refclk as output: input buffer and pull-down off.
// - MAC mode refclk input: pull-down on by default.
// - Refclk output strength from clock strength bit: low weak, high strong.
// - PHY mode isolate: refclk buffer, pull-down, driver all off.
// - Mode strap bit 0 with other strap bits selects port mode.
// - Straps are captured when reset is released.
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module rpm_pin_mode
   import rpm_pkg::*;
#(
   parameter logic [7:0] DIV_HALF = RPM_DIV_HALF
) (
   // Clock and reset
   input  wire logic        i_mclk,
   input  wire logic        i_reset,
   // APB slave
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic      [31:0] o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   // Strap pins
   input  wire logic [2:0]  i_port_mode_strap,
   input  wire logic        i_speed_pol_strap,
   input  wire logic        i_duplex_pol_strap,
   // Live indication pins
   input  wire logic        i_port_speed_input_pin,
   input  wire logic        i_port_duplex_input_pin,
   // Internal valid sources
   input  wire logic        i_tx_en,
   input  wire logic        i_crs_dv,
   // Output valid pin
   output logic             o_port_out_valid_pin,
   output logic             o_port_out_valid_oe,
   // Reference clock pin
   input  wire logic        i_port_reference_clock_pin,
   output logic             o_port_reference_clock_pin,
   output logic             o_refclk_oe,
   output logic             o_refclk_strong,
   output logic             o_refclk_pulldown_en,
   output logic             o_refclk_inbuf_en,
   // Resolved link state
   output logic             o_port_mode_phy,
   output logic             o_speed_100,
   output logic             o_full_duplex
);

   // =====================================================================
   // State
   typedef struct packed {
      logic             iso;
      logic             an;
      logic             spd;
      logic             dup;
      logic             clk_dir;
      logic             clk_str;
      logic [1:0]       cap_cnt;
      logic             latched;
      logic [2:0]       mode_strap;
      logic             spd_pol;
      logic             dup_pol;
      rpm_mode_t        mode;
      logic             speed;
      logic             duplex;
      logic             ov;
      logic             ov_oe;
      logic             rc_oe;
      logic             rc_out;
      logic             rc_str;
      logic             rc_pd;
      logic             rc_ib;
      logic [7:0]       div_cnt;
      logic             rc_prev;
      logic [15:0]      edges;
      logic             pready;
      logic             pslverr;
      logic [31:0]      prdata;
      logic             rst_q;
   } rpm_state_t;

   rpm_state_t st;
   rpm_state_t next_st;

   logic [2:0] strap_s;
   logic       spd_pol_s, dup_pol_s, speed_s, duplex_s, refclk_s;

   // =====================================================================
   // Pin synchronisers
   rpm_sync #(
      .WIDTH (8)
   ) u_sync (
      .i_mclk  (i_mclk),
      .i_reset (i_reset),
      .i_async ({i_port_mode_strap, i_speed_pol_strap, i_duplex_pol_strap,
                 i_port_speed_input_pin, i_port_duplex_input_pin,
                 i_port_reference_clock_pin}),
      .o_sync  ({strap_s, spd_pol_s, dup_pol_s, speed_s, duplex_s,
                 refclk_s})
   );

   // =====================================================================
   // Next state
   always_comb
   begin
      next_st = st;
      next_st.rst_q = 1'b0;

      // Straps settle through the synchroniser before they are taken
      // capture after release
      if (!st.latched)
      begin
         if (st.cap_cnt == RPM_CAP_DELAY)
         begin
            next_st.latched    = 1'b1;
            next_st.mode_strap = strap_s;
            next_st.spd_pol    = spd_pol_s;
            next_st.dup_pol    = dup_pol_s;
            next_st.mode = (strap_s == RPM_STRAP_PHY_CODE) ? RPM_MODE_PHY
                                                           : RPM_MODE_MAC;
         end
         else
         begin
            next_st.cap_cnt = st.cap_cnt + 2'h1;
         end
      end
      // mode held until reset: nothing else writes it

      if (st.mode == RPM_MODE_MAC && st.an)
      begin
         next_st.speed  = speed_s ^ st.spd_pol;
         next_st.duplex = duplex_s ^ st.dup_pol;
      end
      else
      begin
         next_st.speed  = st.spd;
         next_st.duplex = st.dup;
      end

      next_st.ov    = (st.mode == RPM_MODE_MAC) ? i_tx_en : i_crs_dv;
      next_st.ov_oe = (st.mode == RPM_MODE_MAC) || !st.iso;

      // reference clock pad control
      // Isolate in PHY mode overrides the direction bit on all three
      next_st.rc_oe  = st.clk_dir && !(st.mode == RPM_MODE_PHY && st.iso);
      next_st.rc_pd  = !st.clk_dir && !(st.mode == RPM_MODE_PHY && st.iso);
      next_st.rc_ib  = !st.clk_dir && !(st.mode == RPM_MODE_PHY && st.iso);
      next_st.rc_str = st.clk_str;

      // refclk source when driven; divided from mclk in this model
      if (!st.clk_dir || st.div_cnt == DIV_HALF - 8'h01)
      begin
         next_st.div_cnt = 8'h00;
         next_st.rc_out  = st.clk_dir && !st.rc_out;
      end
      else
      begin
         next_st.div_cnt = st.div_cnt + 8'h01;
      end

      // Rising edges of an incoming refclk, for software to see it running
      next_st.rc_prev = refclk_s;
      if (!st.clk_dir && st.rc_ib && refclk_s && !st.rc_prev)
      begin
         next_st.edges = st.edges + 16'h0001;
      end

      // APB: answer in the second access cycle; write at the pready edge
      next_st.pready  = 1'b0;
      next_st.pslverr = 1'b0;
      if (i_psel && i_penable && !st.pready)
      begin
         next_st.pready = 1'b1;
         next_st.prdata = 32'h0000_0000;
         if (i_paddr == RPM_OFS_BASIC_CTRL)
         begin
            next_st.prdata[RPM_BC_DUPLEX] = st.dup;
            next_st.prdata[RPM_BC_ISO]    = st.iso;
            next_st.prdata[RPM_BC_AN]     = st.an;
            next_st.prdata[RPM_BC_SPEED]  = st.spd;
         end
         else if (i_paddr == RPM_OFS_SPECIAL_CTRL)
         begin
            next_st.prdata[RPM_SC_CLK_DIR] = st.clk_dir;
            next_st.prdata[RPM_SC_CLK_STR] = st.clk_str;
         end
         else if (i_paddr == RPM_OFS_STATUS)
         begin
            next_st.prdata[RPM_ST_MODE]    = (st.mode == RPM_MODE_PHY);
            next_st.prdata[RPM_ST_SPEED]   = st.speed;
            next_st.prdata[RPM_ST_DUPLEX]  = st.duplex;
            next_st.prdata[RPM_ST_STRAP+:RPM_STRAP_W] = st.mode_strap;
            next_st.prdata[RPM_ST_SPD_POL] = st.spd_pol;
            next_st.prdata[RPM_ST_DUP_POL] = st.dup_pol;
            next_st.prdata[RPM_ST_LATCHED] = st.latched;
            next_st.prdata[RPM_ST_EDGES+:16] = st.edges;
         end
         else
         begin
            next_st.pslverr = 1'b1;
         end
      end
      if (i_psel && i_penable && st.pready && i_pwrite)
      begin
         if (i_paddr == RPM_OFS_BASIC_CTRL)
         begin
            next_st.dup = i_pwdata[RPM_BC_DUPLEX];
            next_st.iso = i_pwdata[RPM_BC_ISO];
            next_st.an  = i_pwdata[RPM_BC_AN];
            next_st.spd = i_pwdata[RPM_BC_SPEED];
         end
         else if (i_paddr == RPM_OFS_SPECIAL_CTRL)
         begin
            next_st.clk_dir = i_pwdata[RPM_SC_CLK_DIR];
            next_st.clk_str = i_pwdata[RPM_SC_CLK_STR];
         end
      end
   end

   // =====================================================================
   // Registers
   always_ff @(posedge i_mclk)
   begin
      if (i_reset)
      begin
         st         <= '0;
         st.iso     <= RPM_RST_ISO;
         st.an      <= RPM_RST_AN;
         st.spd     <= RPM_RST_SPEED;
         st.dup     <= RPM_RST_DUPLEX;
         st.clk_dir <= RPM_RST_CLK_DIR;
         st.clk_str <= RPM_RST_CLK_STR;
         st.mode    <= RPM_MODE_MAC;
         st.rst_q   <= 1'b1;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign o_prdata                   = st.prdata;
   assign o_pready                   = st.pready;
   assign o_pslverr                  = st.pslverr;
   assign o_port_out_valid_pin       = st.ov;
   assign o_port_out_valid_oe        = st.ov_oe;
   assign o_port_reference_clock_pin = st.rc_out;
   assign o_refclk_oe                = st.rc_oe;
   assign o_refclk_strong            = st.rc_str;
   assign o_refclk_pulldown_en       = st.rc_pd;
   assign o_refclk_inbuf_en          = st.rc_ib;
   assign o_port_mode_phy            = (st.mode == RPM_MODE_PHY);
   assign o_speed_100                = st.speed;
   assign o_full_duplex              = st.duplex;

   // =====================================================================
   // Checks
   default clocking cb @(posedge i_mclk); endclocking
   // Held off one edge past release: outputs still show reset values
   default disable iff (i_reset || st.rst_q);

   property p_mac_valid;
      st.mode == RPM_MODE_MAC |=> o_port_out_valid_pin == $past(i_tx_en)
                                  && o_port_out_valid_oe;
   endproperty
   a_mac_valid: assert property (p_mac_valid)
      else $error("MAC mode valid pin does not follow tx_en");
   property p_phy_valid;
      st.mode == RPM_MODE_PHY |=> o_port_out_valid_pin == $past(i_crs_dv);
   endproperty
   a_phy_valid: assert property (p_phy_valid)
      else $error("PHY mode valid pin does not follow crs_dv");
   property p_phy_iso_valid;
      st.mode == RPM_MODE_PHY && st.iso |=> !o_port_out_valid_oe;
   endproperty
   a_phy_iso_valid: assert property (p_phy_iso_valid)
      else $error("Valid driver on while isolated");
   property p_speed_live;
      st.mode == RPM_MODE_MAC && st.an
         |=> o_speed_100 == ($past(speed_s) ^ $past(st.spd_pol));
   endproperty
   a_speed_live: assert property (p_speed_live)
      else $error("Speed does not follow pin with strap polarity");
   property p_speed_override;
      !st.an || st.mode == RPM_MODE_PHY |=> o_speed_100 == $past(st.spd);
   endproperty
   a_speed_override: assert property (p_speed_override)
      else $error("Speed not taken from control bit");
   property p_duplex_live;
      st.mode == RPM_MODE_MAC && st.an
         |=> o_full_duplex == ($past(duplex_s) ^ $past(st.dup_pol));
   endproperty
   a_duplex_live: assert property (p_duplex_live)
      else $error("Duplex does not follow pin with strap polarity");
   property p_duplex_override;
      !st.an || st.mode == RPM_MODE_PHY |=> o_full_duplex == $past(st.dup);
   endproperty
   a_duplex_override: assert property (p_duplex_override)
      else $error("Duplex not taken from control bit");
   property p_refclk_out;
      st.clk_dir && !(st.mode == RPM_MODE_PHY && st.iso)
         |=> o_refclk_oe && !o_refclk_pulldown_en && !o_refclk_inbuf_en;
   endproperty
   a_refclk_out: assert property (p_refclk_out)
      else $error("Refclk output with input buffer or pull-down on");
   property p_refclk_in;
      st.mode == RPM_MODE_MAC && !st.clk_dir
         |=> !o_refclk_oe && o_refclk_pulldown_en;
   endproperty
   a_refclk_in: assert property (p_refclk_in)
      else $error("MAC refclk input without pull-down");

   property p_refclk_str;
      ##1 o_refclk_strong == $past(st.clk_str);
   endproperty
   a_refclk_str: assert property (p_refclk_str)
      else $error("Refclk strength does not follow strength bit");

   property p_phy_iso_clk;
      st.mode == RPM_MODE_PHY && st.iso
         |=> !o_refclk_oe && !o_refclk_pulldown_en && !o_refclk_inbuf_en;
   endproperty
   a_phy_iso_clk: assert property (p_phy_iso_clk)
      else $error("Refclk pad active while isolated");

   property p_strap_capture;
      $rose(st.latched) |-> st.mode_strap == $past(strap_s)
                            && o_port_mode_phy ==
                               ($past(strap_s) == RPM_STRAP_PHY_CODE);
   endproperty
   a_strap_capture: assert property (p_strap_capture)
      else $error("Strap capture mismatch");

   property p_mode_hold;
      st.latched |=> $stable(st.mode) && $stable(st.mode_strap);
   endproperty
   a_mode_hold: assert property (p_mode_hold)
      else $error("Latched mode changed before reset");

endmodule // rpm_pin_mode

// [bench/rpm_far_end.sv]
// Purpose: Far-end PHY or MAC model driving live pins and refclk
// Assumes: Free-running reference clock of 800 ns period
// Notes:   Releases the refclk wire while the device drives it
`timescale 1ns/1ps
module rpm_far_end (
   // Commands from bench
   input  wire logic i_speed_ind,
   input  wire logic i_duplex_ind,
   // Device refclk pad
   input  wire logic i_dev_clk,
   input  wire logic i_dev_oe,
   // Pins
   output logic      o_speed_pin,
   output logic      o_duplex_pin,
   output logic      o_refclk_wire
);
   logic clk_own;

   // =====================================================================
   // Reference clock, runs free like a crystal-fed source
   initial
   begin
      clk_own = 1'b0;
      forever #400 clk_own = ~clk_own;
   end

   // In PHY mode this far MAC's TX_EN feeds the data path, not
   // this block, so only the clock and live pins are modelled here
   // one shared pin
   assign o_refclk_wire = i_dev_oe ? i_dev_clk : clk_own;
   assign o_speed_pin   = i_speed_ind;
   assign o_duplex_pin  = i_duplex_ind;
endmodule // rpm_far_end

// [bench/rpm_pin_mode_tb.sv]
// Purpose: Self-checking bench for the port 0 pin mode control
// Assumes: APB answers within the bench timeout
// Notes:   Both port modes are entered by a fresh reset with new straps
`timescale 1ns/1ps
module rpm_pin_mode_tb;
   import rpm_pkg::*;

   logic        i_mclk, i_reset, i_psel, i_penable, i_pwrite;
   logic        i_speed_pol_strap, i_duplex_pol_strap, i_tx_en, i_crs_dv;
   logic [7:0]  i_paddr;
   logic [31:0] i_pwdata, o_prdata, rd, bc, sc;
   logic [2:0]  i_port_mode_strap, strap;
   logic        o_pready, o_pslverr, o_port_out_valid_pin;
   logic        o_port_out_valid_oe, o_port_reference_clock_pin;
   logic        o_refclk_oe, o_refclk_strong, o_refclk_pulldown_en;
   logic        o_refclk_inbuf_en, o_port_mode_phy, o_speed_100;
   logic        o_full_duplex, i_port_speed_input_pin;
   logic        i_port_duplex_input_pin, i_port_reference_clock_pin;
   logic        spd_ind, dup_ind, err, mode, spol, dpol, prev, t, c;
   logic [15:0] cnt0;
   int          errors, n_tests, cycles, m, k;

   rpm_pin_mode dut (.*);

   rpm_far_end far (
      .i_speed_ind   (spd_ind),
      .i_duplex_ind  (dup_ind),
      .i_dev_clk     (o_port_reference_clock_pin),
      .i_dev_oe      (o_refclk_oe),
      .o_speed_pin   (i_port_speed_input_pin),
      .o_duplex_pin  (i_port_duplex_input_pin),
      .o_refclk_wire (i_port_reference_clock_pin)
   );

   // =====================================================================
   // Clock and timeout
   initial
   begin
      i_mclk = 1'b0;
      forever #50 i_mclk = ~i_mclk;
   end

   always @(posedge i_mclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         errors++;
         wrap_up();
      end
   end

   // =====================================================================
   // Shared tasks
   task automatic check(input string nm, input logic [31:0] seen, exp);
      n_tests++;
      if (seen !== exp)
      begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge i_mclk);
      i_psel    <= 1'b1;
      i_penable <= 1'b0;
      i_pwrite  <= w;
      i_paddr   <= a;
      i_pwdata  <= d;
      @(posedge i_mclk);
      i_penable <= 1'b1;
      do @(posedge i_mclk); while (o_pready !== 1'b1);
      rd = o_prdata;
      err = o_pslverr;
      i_psel    <= 1'b0;
      i_penable <= 1'b0;
   endtask

   task automatic do_reset(input logic [2:0] s);
      @(posedge i_mclk);
      spol = 1'($urandom);
      dpol = 1'($urandom);
      i_reset            <= 1'b1;
      i_port_mode_strap  <= s;
      i_speed_pol_strap  <= spol;
      i_duplex_pol_strap <= dpol;
      repeat (12) @(posedge i_mclk);
      i_reset <= 1'b0;
      repeat (6) @(posedge i_mclk);
      strap = s;
      mode = (s == RPM_STRAP_PHY_CODE);
      bc = 32'h0;
      bc[RPM_BC_DUPLEX] = RPM_RST_DUPLEX;
      bc[RPM_BC_AN]     = RPM_RST_AN;
      bc[RPM_BC_SPEED]  = RPM_RST_SPEED;
      sc = {30'h0, RPM_RST_CLK_STR, RPM_RST_CLK_DIR};
   endtask

   // Model of the resolved link state
   function automatic logic exp_spd();
      if (mode || !bc[RPM_BC_AN])
         return bc[RPM_BC_SPEED];
      return spd_ind ^ spol;
   endfunction

   function automatic logic exp_dup();
      if (mode || !bc[RPM_BC_AN])
         return bc[RPM_BC_DUPLEX];
      return dup_ind ^ dpol;
   endfunction

   task automatic check_pads();
      logic iso;
      @(negedge i_mclk);
      iso = mode & bc[RPM_BC_ISO];
      check("mode", o_port_mode_phy, mode);
      check("speed", o_speed_100, exp_spd());
      check("duplex", o_full_duplex, exp_dup());
      check("valid_oe", o_port_out_valid_oe, !iso);
      check("refclk_oe", o_refclk_oe, sc[0] & !iso);
      check("pulldown", o_refclk_pulldown_en, !sc[0] & !iso);
      check("inbuf", o_refclk_inbuf_en, !sc[0] & !iso);
      if (sc[0] && !iso)
         check("strong", o_refclk_strong, sc[1]);
   endtask

   // =====================================================================
   // Main sequence
   initial
   begin
      {i_psel, i_penable, i_pwrite, i_tx_en, i_crs_dv} = 5'h00;
      {spd_ind, dup_ind, i_speed_pol_strap, i_duplex_pol_strap} = 4'h0;
      i_reset = 1'b1;
      i_paddr = 8'h00;
      i_pwdata = 32'h0;
      i_port_mode_strap = 3'h0;
      errors = 0;
      n_tests = 0;
      cycles = 0;
      k = $urandom(32'h8252);
      for (m = 0; m < 2; m++)
      begin
         do_reset(m ? RPM_STRAP_PHY_CODE : 3'($urandom_range(7, 2)));
         apb(1'b0, RPM_OFS_BASIC_CTRL, 32'h0);
         check("bc_reset", rd, bc);
         apb(1'b0, RPM_OFS_SPECIAL_CTRL, 32'h0);
         check("sc_reset", rd, sc);
         apb(1'b0, RPM_OFS_STATUS, 32'h0);
         check("status", rd[15:0], {5'h0, 1'b1, dpol, spol, 1'b0, strap,
               1'b0, exp_dup(), exp_spd(), mode});
         apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
         check("wr_err", err, 1'b1);
         apb(1'b0, 8'h0C, 32'h0);
         check("rd_err", err, 1'b1);
         check("rd_zero", rd, 32'h0);
         apb(1'b1, RPM_OFS_STATUS, 32'hFFFF_FFFF);
         check("ro_err", err, 1'b0);
         // Every isolate, direction and autoneg combination
         for (k = 0; k < 8; k++)
         begin
            bc = 32'h0;
            bc[RPM_BC_ISO]    = k[0];
            bc[RPM_BC_AN]     = k[2];
            bc[RPM_BC_SPEED]  = 1'($urandom);
            bc[RPM_BC_DUPLEX] = 1'($urandom);
            sc = {30'h0, 1'($urandom), k[1]};
            spd_ind <= 1'($urandom);
            dup_ind <= 1'($urandom);
            apb(1'b1, RPM_OFS_BASIC_CTRL, bc);
            apb(1'b1, RPM_OFS_SPECIAL_CTRL, sc);
            repeat (5) @(posedge i_mclk);
            check_pads();
            apb(1'b0, RPM_OFS_BASIC_CTRL, 32'h0);
            check("bc_rd", rd, bc);
         end
         bc = 32'h0;
         sc = 32'h0;
         apb(1'b1, RPM_OFS_BASIC_CTRL, bc);
         apb(1'b1, RPM_OFS_SPECIAL_CTRL, sc);
         // Valid pin follows the source of the mode one edge later
         // The pin still shows the source left over from earlier tests
         prev = mode ? i_crs_dv : i_tx_en;
         repeat (24)
         begin
            @(posedge i_mclk);
            t = 1'($urandom);
            c = 1'($urandom);
            i_tx_en  <= t;
            i_crs_dv <= c;
            @(negedge i_mclk);
            check("valid", o_port_out_valid_pin, prev);
            prev = mode ? c : t;
         end
         // Refclk edges counted only while it is an input
         apb(1'b0, RPM_OFS_STATUS, 32'h0);
         cnt0 = rd[31:16];
         repeat (40) @(posedge i_mclk);
         apb(1'b0, RPM_OFS_STATUS, 32'h0);
         check("edges", rd[31:16] != cnt0, 1'b1);
         // Driven refclk toggles and is not counted back as an input
         apb(1'b1, RPM_OFS_SPECIAL_CTRL, 32'h1);
         apb(1'b0, RPM_OFS_STATUS, 32'h0);
         cnt0 = rd[31:16];
         @(negedge i_mclk);
         t = o_port_reference_clock_pin;
         repeat (RPM_DIV_HALF) @(negedge i_mclk);
         check("refclk_out", o_port_reference_clock_pin, !t);
         apb(1'b0, RPM_OFS_STATUS, 32'h0);
         check("edges_out", rd[31:16], cnt0);
         apb(1'b1, RPM_OFS_SPECIAL_CTRL, 32'h0);
         // Strap pins moving after latch must not change the mode
         i_port_mode_strap <= ~strap;
         repeat (8) @(posedge i_mclk);
         check_pads();
      end
      wrap_up();
   end
endmodule // rpm_pin_mode_tb
